// ===== common/fus_pkg.sv
package fus_pkg;
    // ****************************************
    // geometry
    // ****************************************
    localparam int SIG_BYTES = 512;
    localparam int SIG_WORDS = SIG_BYTES / 4;
    localparam int IDX_W = $clog2(SIG_WORDS);

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_ISTAT = 8'h0c;
    localparam logic [7:0] OFS_IMASK = 8'h10;

    // ****************************************
    // field positions and values
    // ****************************************
    localparam int MODE_RDY_IE_BIT = 0;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_CMDERR_BIT = 1;
    localparam int STAT_FLERR_BIT = 2;
    localparam int STAT_SIGMODE_BIT = 3;
    localparam int EV_W = 3;
    localparam int EV_DONE = 0;
    localparam int EV_CMDERR = 1;
    localparam int EV_FLERR = 2;
    localparam logic [7:0] CMD_KEY = 8'h5a;
    localparam logic [EV_W-1:0] IMASK_RESET = 3'h0;
    localparam logic DONE_RESET = 1'b1;

    // command codes
    localparam logic [7:0] CODE_SIG_PROGRAM = 8'h12;
    localparam logic [7:0] CODE_SIG_ERASE = 8'h13;
    localparam logic [7:0] CODE_START_SIG_READ = 8'h14;
    localparam logic [7:0] CODE_STOP_SIG_READ = 8'h15;

    // command register layout
    typedef struct packed {
        logic [7:0] key;
        logic [15:0] arg;
        logic [7:0] code;
    } fus_cmd_t;

    // flash read port
    typedef struct packed {
        logic rd;
        logic [31:0] addr;
    } fus_rdreq_t;

    typedef enum {
        ST_IDLE,
        ST_PROG,
        ST_PROG_VFY,
        ST_ERASE,
        ST_ERASE_VFY
    } fus_state_t;
endpackage : fus_pkg

// ===== rtl/fus_seq.sv
//Contract
// - a 512-byte signature store is readable, programmable and erasable by commands
// - start-read command enters signature read mode; argument ignored
// - done flag drops once store is readable; software waits for that drop
// - in read mode, lowest 512 flash bytes return the signature store
// - stop-read completion raises done flag and interrupts when enabled
// - wrong protection key on read, program or erase sets command error
// - program command copies page to store, raises done, interrupts if enabled
// - after programming, verify store and flag flash error on mismatch
// - erase command clears store, raises done, interrupts if enabled
// - after erasing, verify store and flag flash error on mismatch
// - completion interrupt only while ready interrupt enable bit is one
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module fus_seq
    import fus_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic PAGE_WE,
    input wire logic [IDX_W-1:0] PAGE_IDX,
    input wire logic [31:0] PAGE_WDATA,
    input wire fus_rdreq_t FLASH_REQ,
    input wire logic [31:0] PLANE_RDATA,
    output logic [31:0] FLASH_RDATA,
    output logic SIG_MODE,
    output logic SEQ_BUSY,
    output logic IRQ
);

    // ****************************************
    // storage
    // ****************************************
    // signature store and page buffer are one word per entry
    // neither array is reset: contents are unknown until erased or loaded
    // software must erase the store before a first program,
    // because programming can only clear bits
    logic [31:0] sig_mem [SIG_WORDS];
    logic [31:0] page_mem [SIG_WORDS];

    // ****************************************
    // state
    // ****************************************
    fus_state_t state_ff, nxt_state;
    logic [IDX_W-1:0] idx_ff, nxt_idx;
    logic done_ff, nxt_done;
    logic cmderr_ff, nxt_cmderr;
    logic flerr_ff, nxt_flerr;
    logic sigmode_ff, nxt_sigmode;
    logic rdy_ie_ff;
    logic [EV_W-1:0] istat_ff, imask_ff;
    logic [31:0] prdata_ff, flash_rdata_ff;

    // ****************************************
    // bus decode
    // ****************************************
    // zero wait states: every access phase completes at its first edge
    // writes land at the access edge, reads are captured at the setup edge
    // unmapped offsets answer with an error and change nothing
    wire setup = PSEL & ~PENABLE;
    wire acc = PSEL & PENABLE;
    wire hit_mode = (PADDR == OFS_MODE);
    wire hit_cmd = (PADDR == OFS_CMD);
    wire hit_stat = (PADDR == OFS_STAT);
    wire hit_istat = (PADDR == OFS_ISTAT);
    wire hit_imask = (PADDR == OFS_IMASK);
    wire mapped = hit_mode | hit_cmd | hit_stat | hit_istat | hit_imask;
    wire wr = acc & PWRITE & mapped;
    wire cmd_wr = wr & hit_cmd;
    fus_cmd_t cmd;
    assign cmd = PWDATA;

    // command classification
    wire key_ok = (cmd.key == CMD_KEY);
    wire is_start = (cmd.code == CODE_START_SIG_READ);
    wire is_stop = (cmd.code == CODE_STOP_SIG_READ);
    wire is_prog = (cmd.code == CODE_SIG_PROGRAM);
    wire is_erase = (cmd.code == CODE_SIG_ERASE);
    wire known = is_start | is_stop | is_prog | is_erase;
    wire idle = (state_ff == ST_IDLE);
    // in read mode only stop is legal, outside it stop is meaningless
    wire legal = idle & known & (sigmode_ff ? is_stop : ~is_stop);
    wire accept = cmd_wr & key_ok & legal;
    wire reject = cmd_wr & ~(key_ok & legal);
    wire last = (idx_ff == IDX_W'(SIG_WORDS - 1));

    // verify compare on the current word
    wire prog_bad = (sig_mem[idx_ff] != page_mem[idx_ff]);
    wire erase_bad = (sig_mem[idx_ff] != 32'hffffffff);

    // ****************************************
    // sequencer
    // ****************************************
    // program and erase each run one word per cycle through the store,
    // then a second pass compares every word; the done flag rises only
    // after the last compare, so a failing word is flagged no later than done
    // read mode has no busy state of its own: it is held by a flag
    // next-state and flag logic
    always_comb
    begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        nxt_done = done_ff;
        nxt_cmderr = cmderr_ff;
        nxt_flerr = flerr_ff;
        nxt_sigmode = sigmode_ff;
        if (accept)
        begin
            nxt_done = 1'b0;
            nxt_cmderr = 1'b0;
            nxt_flerr = 1'b0;
            nxt_idx = '0;
            if (is_start)
                nxt_sigmode = 1'b1;
            else if (is_stop)
            begin
                nxt_sigmode = 1'b0;
                nxt_done = 1'b1;
            end
            else if (is_prog)
                nxt_state = ST_PROG;
            else
                nxt_state = ST_ERASE;
        end
        else if (reject)
            nxt_cmderr = 1'b1;
        case (state_ff)
            ST_IDLE:
            begin
            end
            ST_PROG, ST_ERASE:
            begin
                nxt_idx = idx_ff + IDX_W'(1);
                if (last)
                begin
                    nxt_idx = '0;
                    nxt_state = (state_ff == ST_PROG) ? ST_PROG_VFY : ST_ERASE_VFY;
                end
            end
            ST_PROG_VFY, ST_ERASE_VFY:
            begin
                nxt_idx = idx_ff + IDX_W'(1);
                if ((state_ff == ST_PROG_VFY) ? prog_bad : erase_bad)
                    nxt_flerr = 1'b1;
                if (last)
                begin
                    nxt_state = ST_IDLE;
                    nxt_done = 1'b1;
                end
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state_ff <= ST_IDLE;
            idx_ff <= '0;
            done_ff <= DONE_RESET;
            cmderr_ff <= 1'b0;
            flerr_ff <= 1'b0;
            sigmode_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
            done_ff <= nxt_done;
            cmderr_ff <= nxt_cmderr;
            flerr_ff <= nxt_flerr;
            sigmode_ff <= nxt_sigmode;
        end
    end

    // ****************************************
    // arrays
    // ****************************************
    // page buffer fill and signature store update; program only clears bits
    always_ff @(posedge CLK)
    begin
        if (PAGE_WE)
            page_mem[PAGE_IDX] <= PAGE_WDATA;
        if (state_ff == ST_PROG)
            sig_mem[idx_ff] <= sig_mem[idx_ff] & page_mem[idx_ff];
        else if (state_ff == ST_ERASE)
            sig_mem[idx_ff] <= 32'hffffffff;
    end

    // ****************************************
    // flash read path
    // ****************************************
    // the overlay only covers the lowest store-sized window of the map;
    // every other address, and every address outside read mode,
    // comes from the memory plane unchanged
    wire low_area = (FLASH_REQ.addr < 32'(SIG_BYTES));
    wire [IDX_W-1:0] rd_idx = FLASH_REQ.addr[IDX_W+1:2];
    wire use_sig = sigmode_ff & low_area;

    // registered read data, overlay or plane
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            flash_rdata_ff <= '0;
        else if (FLASH_REQ.rd)
            flash_rdata_ff <= use_sig ? sig_mem[rd_idx] : PLANE_RDATA;
    end

    // ****************************************
    // software registers
    // ****************************************
    // events are rising edges of the done, command error and flash error flags, caught one cycle early
    // from the next-state values so the sticky bit lines up with the flag
    // a write of one clears a sticky bit, but a new event in the same
    // cycle keeps it set, so no event is ever lost
    wire [EV_W-1:0] ev_set;
    assign ev_set[EV_DONE] = ~done_ff & nxt_done;
    assign ev_set[EV_CMDERR] = ~cmderr_ff & nxt_cmderr;
    assign ev_set[EV_FLERR] = ~flerr_ff & nxt_flerr;
    wire [EV_W-1:0] ev_clr = (wr & hit_istat) ? PWDATA[EV_W-1:0] : '0;
    wire [EV_W-1:0] nxt_istat = (istat_ff & ~ev_clr) | ev_set;

    wire [31:0] stat_word = {28'h0, sigmode_ff, flerr_ff, cmderr_ff, done_ff};
    wire [31:0] rd_mux = hit_mode ? {31'h0, rdy_ie_ff} :
        hit_stat ? stat_word :
        hit_istat ? {29'h0, istat_ff} :
        hit_imask ? {29'h0, imask_ff} : 32'h0;

    // mode, mask, sticky events and read data capture
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            rdy_ie_ff <= 1'b0;
            imask_ff <= IMASK_RESET;
            istat_ff <= '0;
            prdata_ff <= '0;
        end
        else
        begin
            if (wr & hit_mode)
                rdy_ie_ff <= PWDATA[MODE_RDY_IE_BIT];
            if (wr & hit_imask)
                imask_ff <= PWDATA[EV_W-1:0];
            istat_ff <= nxt_istat; // set wins over clear
            if (setup & ~PWRITE)
                prdata_ff <= rd_mux;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // busy covers read mode too, since the plane is hidden there
    // done interrupt needs the mode enable as well as its mask bit
    wire [EV_W-1:0] gate = {imask_ff[EV_FLERR], imask_ff[EV_CMDERR], imask_ff[EV_DONE] & rdy_ie_ff};
    assign IRQ = |(istat_ff & gate);
    assign PRDATA = prdata_ff;
    assign PREADY = 1'b1;
    assign PSLVERR = acc & ~mapped;
    assign FLASH_RDATA = flash_rdata_ff;
    assign SIG_MODE = sigmode_ff;
    assign SEQ_BUSY = ~idle | sigmode_ff; // fetch must be held off
endmodule : fus_seq
`default_nettype wire

// ===== bench/fus_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module fus_monitor
    import fus_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire fus_rdreq_t FLASH_REQ,
    input wire logic [31:0] PLANE_RDATA,
    input wire logic [31:0] FLASH_RDATA,
    input wire logic SIG_MODE,
    input wire logic SEQ_BUSY
);
    // ****
    // command write decode
    // ****
    wire cmd_wr = PSEL && PENABLE && PWRITE && PADDR == OFS_CMD;
    wire key_ok = PWDATA[31:24] == CMD_KEY;
    wire go_idle = cmd_wr && key_ok && !SEQ_BUSY;
    wire [7:0] code = PWDATA[7:0];
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    a_start_read: assert property (go_idle && code == CODE_START_SIG_READ |=> SIG_MODE)
        else $error("start read not entered");
    a_stop_read: assert property (cmd_wr && key_ok && SIG_MODE && code == CODE_STOP_SIG_READ
        |=> !SIG_MODE && !SEQ_BUSY) else $error("stop read not done");
    a_mode_holds: assert property (SIG_MODE && !cmd_wr |=> SIG_MODE) else $error("read mode lost");
    a_bad_key: assert property (cmd_wr && !key_ok && !SEQ_BUSY |=> !SEQ_BUSY && !SIG_MODE)
        else $error("bad key accepted");
    a_erase_busy: assert property (go_idle && code == CODE_SIG_ERASE |=> SEQ_BUSY [*8])
        else $error("erase not busy");
    a_erase_len: assert property (go_idle && code == CODE_SIG_ERASE |-> ##256 SEQ_BUSY ##1 !SEQ_BUSY)
        else $error("erase length wrong");
    a_prog_len: assert property (go_idle && code == CODE_SIG_PROGRAM |-> ##256 SEQ_BUSY ##1 !SEQ_BUSY)
        else $error("program length wrong");
    a_plane_read: assert property (FLASH_REQ.rd && (!SIG_MODE || FLASH_REQ.addr >= 32'h200)
        |=> FLASH_RDATA == $past(PLANE_RDATA)) else $error("plane data wrong");
endmodule : fus_monitor
bind fus_seq fus_monitor i_fus_monitor (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .FLASH_REQ(FLASH_REQ), .PLANE_RDATA(PLANE_RDATA),
    .FLASH_RDATA(FLASH_RDATA), .SIG_MODE(SIG_MODE), .SEQ_BUSY(SEQ_BUSY));
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb import fus_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pwe = 1'b0, se;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0, pwdat = 32'h0, plane = 32'hc3a5_0f1e, prd, frd, r;
    logic [IDX_W-1:0] pidx = '0;
    fus_rdreq_t freq = '0;
    logic prdy, perr, smode, busy, irq;
    int n_errors = 0, checks = 0;
    fus_seq i_fus_seq (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
        .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .PAGE_WE(pwe), .PAGE_IDX(pidx),
        .PAGE_WDATA(pwdat), .FLASH_REQ(freq), .PLANE_RDATA(plane), .FLASH_RDATA(frd), .SIG_MODE(smode),
        .SEQ_BUSY(busy), .IRQ(irq));
    // ****
    // clock and helpers
    // ****
    initial forever #5 clk = ~clk;
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // one apb transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1)
            @(posedge clk);
        r = prd;
        se = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, r, exp); // compare of a register read
    endtask : rdc
    task cmd(input logic [7:0] k, input logic [7:0] c);
        apb(1'b1, OFS_CMD, {k, 16'hbeef, c}); // argument is junk on purpose
    endtask : cmd
    task irq_chk(input logic e);
        #1;
        chk("irq", {31'h0, irq}, {31'h0, e});
    endtask : irq_chk
    // wait until busy drops; the read-mode flash checks still run while busy
    task idle_wait;
        @(posedge clk);
        while (busy !== 1'b0)
            @(posedge clk);
    endtask : idle_wait
    task frd_chk(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk);
        freq <= '{1'b1, a};
        @(posedge clk);
        freq.rd <= 1'b0;
        #1;
        chk("flash data", frd, exp);
    endtask : frd_chk
    // page word i is x xor i; full page before program
    task load(input logic [31:0] x);
        for (int i = 0; i < SIG_WORDS; i++)
        begin
            @(posedge clk);
            pwe <= 1'b1;
            pidx <= i[IDX_W-1:0];
            pwdat <= x ^ 32'(i);
        end
        @(posedge clk);
        pwe <= 1'b0;
    endtask : load
    // ****
    // scenarios
    // ****
    task t_reset;
        rdc("status", OFS_STAT, 32'h1);
        rdc("imask", OFS_IMASK, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", {31'h0, se}, 32'h1);
    endtask : t_reset
    task t_bad_key;
        apb(1'b1, OFS_MODE, 32'h1);
        apb(1'b1, OFS_IMASK, 32'h7);
        cmd(8'h00, CODE_START_SIG_READ);
        rdc("status", OFS_STAT, 32'h3);
        irq_chk(1'b1);
        apb(1'b1, OFS_ISTAT, 32'h7);
        irq_chk(1'b0);
    endtask : t_bad_key
    task t_erase;
        cmd(CMD_KEY, CODE_SIG_ERASE);
        rdc("status", OFS_STAT, 32'h0);
        idle_wait;
        rdc("status", OFS_STAT, 32'h1);
        irq_chk(1'b1);
        apb(1'b1, OFS_ISTAT, 32'h7);
        irq_chk(1'b0);
    endtask : t_erase
    task t_sig_read;
        load(32'h00ff_0000);
        cmd(CMD_KEY, CODE_SIG_PROGRAM);
        idle_wait;
        rdc("status", OFS_STAT, 32'h1);
        apb(1'b1, OFS_ISTAT, 32'h7);
        cmd(CMD_KEY, CODE_START_SIG_READ);
        rdc("status", OFS_STAT, 32'h8);
        chk("sig mode", {31'h0, smode}, 32'h1);
        frd_chk(32'h0, 32'h00ff_0000);
        frd_chk(32'h1fc, 32'h00ff_007f);
        frd_chk(32'h200, plane);
        cmd(CMD_KEY, CODE_STOP_SIG_READ);
        rdc("status", OFS_STAT, 32'h1);
        chk("sig mode", {31'h0, smode}, 32'h0);
        irq_chk(1'b1);
        frd_chk(32'h0, plane);
    endtask : t_sig_read
    // program over cleared bits must fail verify; irq off with enable bit low
    task t_prog_fail;
        apb(1'b1, OFS_MODE, 32'h0);
        apb(1'b1, OFS_ISTAT, 32'h7);
        apb(1'b1, OFS_IMASK, 32'h1);
        load(32'hffff_ffff);
        cmd(CMD_KEY, CODE_SIG_PROGRAM);
        idle_wait;
        rdc("status", OFS_STAT, 32'h5);
        irq_chk(1'b0);
    endtask : t_prog_fail
    task final_report;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_bad_key;
        t_erase;
        t_sig_read;
        t_prog_fail;
        final_report;
    end
    // watchdog
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        final_report;
    end
endmodule : tb
`default_nettype wire
